// ---- rtl/cos_shaper.sv ----
// Phase to cosine amplitude conversion with a parabolic approximation.
`timescale 1ns/100ps
module cos_shaper
  import dds_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Truncated phase in, signed amplitude out.
  input wire logic [LUT_IN_W-1:0] phase,
  output logic signed [AMP_W-1:0] amp_q
);

  logic [LUT_IN_W-1:0] rot;
  logic [LUT_IN_W-2:0] frac;
  logic [2*(LUT_IN_W-1)-1:0] prod;
  logic [AMP_W-2:0] mag;

  // A quarter turn ahead turns the half-wave sine into a cosine.
  // The parabola keeps the block to one multiplier instead of a large table.
  always_comb begin
    rot = phase + QUARTER_TURN;
    frac = rot[LUT_IN_W-2:0];
    prod = frac * (LUT_IN_W-1)'(~frac);
    mag = prod[33:21];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      amp_q <= '0;
    end else if (rot[LUT_IN_W-1]) begin
      amp_q <= -$signed({1'b0, mag});
    end else begin
      amp_q <= $signed({1'b0, mag});
    end
  end

endmodule : cos_shaper

// ---- rtl/dds_phase_amplitude_core.sv ----
// Synthesizer core: registers, update logic, sweep, phase datapath and amplitude scaling.
`timescale 1ns/100ps
module dds_phase_amplitude_core
  import dds_pkg::*;
#(
  parameter int PROFILES = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Device pins.
  input wire logic io_update,
  input wire logic profile_select_low,
  input wire logic profile_select_high,
  input wire logic amplitude_keying_pin,
  // Internal RAM output word.
  input wire logic [31:0] ram_word,
  // To the DAC and comparator.
  output logic [AMP_W-1:0] dac_code_q,
  output logic comp_power_down
);

  // ************************************************************
  // Register bus slave
  // ************************************************************

  cfg_s buf_q;
  cfg_s act_q;
  logic [ACC_W-1:0] ftw_buf_q [PROFILES];
  logic [POW_W-1:0] pow_buf_q [PROFILES];
  logic [ACC_W-1:0] act_ftw_q;
  logic [POW_W-1:0] act_pow_q;
  logic ack_q;
  logic wr_do;
  logic [31:0] wmerge_ctrl;
  logic [31:0] status;
  logic [AMP_W-1:0] scale;
  logic [ACC_W-1:0] phase_acc_q;
  logic swp_at_top;
  logic swp_at_bottom;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Every access is answered one cycle after it appears; no access stalls longer.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_do = avs_write && ack_q;
  assign wmerge_ctrl = merge(buf_q.ctrl, avs_writedata, avs_byteenable);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_q <= '0;
      buf_q.ctrl <= CTRL_BUF_RST; // R6
    end else if (wr_do) begin
      case (avs_address)
        OFS_CTRL: buf_q.ctrl <= wmerge_ctrl;
        OFS_ASF: buf_q.amplitude_scale_register <= 16'(merge({16'h0000, buf_q.amplitude_scale_register}, avs_writedata, avs_byteenable));
        OFS_OSK_RATE: begin
          buf_q.osk_rate <= RATE_W'(merge({24'h000000, buf_q.osk_rate}, avs_writedata,
                                  avs_byteenable));
        end
        OFS_SWP_START: buf_q.swp_start <= merge(buf_q.swp_start, avs_writedata, avs_byteenable);
        OFS_SWP_TERM: buf_q.swp_term <= merge(buf_q.swp_term, avs_writedata, avs_byteenable);
        OFS_DELTA_RISE: begin
          buf_q.delta_rise <= merge(buf_q.delta_rise, avs_writedata, avs_byteenable);
        end
        OFS_DELTA_FALL: begin
          buf_q.delta_fall <= merge(buf_q.delta_fall, avs_writedata, avs_byteenable);
        end
        OFS_SWP_RATE: begin
          {buf_q.rate_fall, buf_q.rate_rise} <=
            16'(merge({16'h0000, buf_q.rate_fall, buf_q.rate_rise}, avs_writedata,
                  avs_byteenable));
        end
        default: ;
      endcase
    end
  end

  // Profile pages: one static tuning word and one phase word per profile.
  for (genvar p = 0; p < PROFILES; p++) begin : g_profile
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        ftw_buf_q[p] <= '0;
        pow_buf_q[p] <= '0;
      end else if (wr_do && avs_address[3:2] == 2'(p)) begin
        if (avs_address[7:4] == OFS_FTW_PAGE) begin
          ftw_buf_q[p] <= merge(ftw_buf_q[p], avs_writedata, avs_byteenable);
        end
        if (avs_address[7:4] == OFS_POW_PAGE) begin
          pow_buf_q[p] <= POW_W'(merge({18'h00000, pow_buf_q[p]}, avs_writedata,
                                avs_byteenable));
        end
      end
    end
  end

  assign status = {phase_acc_q[31:18], swp_at_bottom, swp_at_top, 2'b00, scale};

  // Read data is captured while waitrequest is high, so it stands on the answer edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      if (avs_address[7:4] == OFS_FTW_PAGE) begin
        avs_readdata <= ftw_buf_q[avs_address[3:2]];
      end else if (avs_address[7:4] == OFS_POW_PAGE) begin
        avs_readdata <= {18'h00000, pow_buf_q[avs_address[3:2]]};
      end else begin
        case (avs_address)
          OFS_CTRL: avs_readdata <= buf_q.ctrl;
          OFS_ASF: avs_readdata <= {16'h0000, buf_q.amplitude_scale_register};
          OFS_OSK_RATE: avs_readdata <= {24'h000000, buf_q.osk_rate};
          OFS_SWP_START: avs_readdata <= buf_q.swp_start;
          OFS_SWP_TERM: avs_readdata <= buf_q.swp_term;
          OFS_DELTA_RISE: avs_readdata <= buf_q.delta_rise;
          OFS_DELTA_FALL: avs_readdata <= buf_q.delta_fall;
          OFS_SWP_RATE: avs_readdata <= {16'h0000, buf_q.rate_fall, buf_q.rate_rise};
          OFS_STATUS: avs_readdata <= status;
          OFS_ACT_CTRL: avs_readdata <= act_q.ctrl;
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  // ************************************************************
  // Update strobe and active register set
  // ************************************************************

  logic io_update_prev_q;
  logic [1:0] prof_prev_q;
  logic [1:0] prof_pins;
  logic prof_change;
  logic upd;
  logic aclr_freq_q;
  logic aclr_phase_q;

  assign prof_pins = {profile_select_high, profile_select_low};

  // While sweeping, the low profile pin steers direction and must not restart the sweep.
  assign prof_change = act_q.ctrl[CTL_SWEEP_EN] ? (prof_pins[1] != prof_prev_q[1])
                                                : (prof_pins != prof_prev_q); // R25
  assign upd = (io_update && !io_update_prev_q) || prof_change ||
               (wr_do && avs_address == OFS_UPDATE && avs_writedata[0]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_update_prev_q <= 1'b0;
      prof_prev_q <= '0;
    end else begin
      io_update_prev_q <= io_update;
      prof_prev_q <= prof_pins;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_q <= '0;
      act_q.ctrl <= CTRL_ACT_RST; // R6
      act_ftw_q <= '0;
      act_pow_q <= '0;
    end else if (upd) begin
      act_q <= buf_q; // R7
      act_ftw_q <= ftw_buf_q[prof_pins]; // R25
      act_pow_q <= pow_buf_q[prof_pins]; // R25
    end
  end

  // One-cycle clear on each update while the auto-clear bit is being loaded.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aclr_freq_q <= 1'b0;
      aclr_phase_q <= 1'b0;
    end else begin
      aclr_freq_q <= upd && buf_q.ctrl[CTL_AUTOCLR_FREQ]; // R13 R15
      aclr_phase_q <= upd && buf_q.ctrl[CTL_AUTOCLR_PHASE]; // R13 R15
    end
  end

  assign comp_power_down = act_q.ctrl[CTL_COMP_PD]; // R17

  // ************************************************************
  // Linear sweep frequency accumulator
  // ************************************************************

  logic [ACC_W-1:0] swp_acc_q;
  logic [RATE_W-1:0] swp_tmr_q;
  logic [ACC_W-1:0] swp_span;
  logic [ACC_W:0] swp_up_sum;
  logic swp_hold_zero;

  // The accumulator holds the offset above the start word, so zero means start.
  assign swp_span = act_q.swp_term - act_q.swp_start;
  assign swp_up_sum = {1'b0, swp_acc_q} + {1'b0, act_q.delta_rise};
  assign swp_at_top = (swp_acc_q == swp_span);
  assign swp_at_bottom = (swp_acc_q == '0);
  assign swp_hold_zero = !act_q.ctrl[CTL_SWEEP_EN] || act_q.ctrl[CTL_CLR_FREQ] || aclr_freq_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      swp_tmr_q <= '0;
    end else if (swp_hold_zero || swp_tmr_q == '0) begin
      swp_tmr_q <= profile_select_low ? act_q.rate_rise : act_q.rate_fall; // R11
    end else begin
      swp_tmr_q <= swp_tmr_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      swp_acc_q <= '0;
    end else if (swp_hold_zero) begin
      swp_acc_q <= '0; // R14 R15 R16
    end else if (swp_tmr_q == '0) begin
      if (profile_select_low) begin
        if (swp_at_top && act_q.ctrl[CTL_NO_DWELL]) begin
          swp_acc_q <= '0; // R12
        end else if (swp_up_sum >= {1'b0, swp_span}) begin
          swp_acc_q <= swp_span; // R28
        end else begin
          swp_acc_q <= swp_up_sum[ACC_W-1:0]; // R11
        end
      end else if (swp_acc_q < act_q.delta_fall) begin
        swp_acc_q <= '0; // R28
      end else begin
        swp_acc_q <= swp_acc_q - act_q.delta_fall; // R11
      end
    end
  end

  // ************************************************************
  // Phase datapath
  // ************************************************************

  logic [ACC_W-1:0] ftw_q;
  logic [POW_W-1:0] pow_d1_q;
  logic [POW_W-1:0] pow_d2_q;
  logic [LUT_IN_W-1:0] lut_phase_q;
  logic [ACC_W-1:0] phase_sum;
  logic [ACC_W-1:0] freq_tuning_word;
  logic [POW_W-1:0] phase_offset_word;
  logic signed [AMP_W-1:0] amp;
  logic signed [2*AMP_W:0] scaled;

  always_comb begin
    if (act_q.ctrl[CTL_RAM_EN] && !act_q.ctrl[CTL_RAM_DEST]) begin
      freq_tuning_word = ram_word; // R8
    end else if (act_q.ctrl[CTL_SWEEP_EN]) begin
      freq_tuning_word = act_q.swp_start + swp_acc_q; // R8
    end else begin
      freq_tuning_word = act_ftw_q; // R8
    end
    if (act_q.ctrl[CTL_RAM_EN] && act_q.ctrl[CTL_RAM_DEST]) begin
      phase_offset_word = ram_word[31:18]; // R9
    end else begin
      phase_offset_word = act_pow_q; // R9
    end
  end

  // Two offset stages match the tuning register plus the accumulator stage.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ftw_q <= '0;
      pow_d1_q <= '0;
      pow_d2_q <= '0;
    end else begin
      ftw_q <= freq_tuning_word;
      pow_d1_q <= phase_offset_word; // R10
      pow_d2_q <= pow_d1_q; // R10
    end
  end

  // A zero tuning word simply leaves the accumulator where it is.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_acc_q <= '0;
    end else if (act_q.ctrl[CTL_CLR_PHASE] || aclr_phase_q) begin
      phase_acc_q <= '0; // R5 R14 R15
    end else begin
      phase_acc_q <= phase_acc_q + ftw_q; // R1
    end
  end

  // The offset sits on the top bits, so its full range is exactly one turn.
  assign phase_sum = phase_acc_q + {pow_d2_q, 18'h00000}; // R2 R4

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lut_phase_q <= '0;
    end else begin
      lut_phase_q <= phase_sum[ACC_W-1 -: LUT_IN_W]; // R3
    end
  end

  cos_shaper u_cos (
    .clk_sys(clk_sys),
    .rst(rst),
    .phase(lut_phase_q),
    .amp_q(amp)
  );

  // ************************************************************
  // Amplitude scaling
  // ************************************************************

  osk_scaler u_osk (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(act_q.ctrl[CTL_OSK_EN]),
    .auto_mode(act_q.ctrl[CTL_OSK_AUTO]),
    .amplitude_scale_register(act_q.amplitude_scale_register),
    .ramp_rate(act_q.osk_rate),
    .amplitude_keying_pin(amplitude_keying_pin),
    .scale_q(scale)
  );

  assign scaled = amp * $signed({1'b0, scale}); // R22

  // Offset binary for the DAC: invert the sign bit of the scaled sample.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dac_code_q <= '0;
    end else begin
      dac_code_q <= {~scaled[2*AMP_W-1], scaled[2*AMP_W-2 -: AMP_W-1]}; // R22
    end
  end

endmodule : dds_phase_amplitude_core

// ---- rtl/dds_pkg.sv ----
// Constants, register map and shared types of the synthesizer datapath core.
// Operation
// R1: Add tuning word to 32-bit accumulator each cycle.
// R2: Add 14-bit phase offset before amplitude conversion.
// R3: Pass only top 19 phase bits onward.
// R4: Full offset range spans one whole cycle.
// R5: Clear bit zeroes accumulator; zero word freezes.
// R6: Active phase clear is 1, buffered 0.
// R7: Update strobe copies all buffered values at once.
// R8: Tuning word from sweep, RAM or static.
// R9: Phase offset from RAM or static register.
// R10: Offset path delayed to match tuning path.
// R11: Sweep enable bit 21 ramps with deltas.
// R12: No-dwell bit decides action at terminal frequency.
// R13: Auto-clear bits 14 and 13 exist.
// R14: Continuous clear bits 11, 10 hold zero.
// R15: Auto-clear zeroes accumulator on each update.
// R16: Auto-clear and continuous clear may coexist.
// R17: Bit 6 powers down the comparator.
// R18: Bit 25 enables shaped amplitude keying.
// R19: Bit 24 selects automatic or manual keying.
// R20: Automatic scale is 14-bit counter, 8-bit rate.
// R21: Scale counts up on high pin, down low.
// R22: Unsigned scale multiplies sine amplitude.
// R23: Amplitude register bits 15:14 choose step size.
// R24: Keying pin driven synchronously, low when unused.
// R25: Profile pin change triggers an internal update. While sweeping, the core updates only on a high pin change.
// R26: Scale counter saturates at zero and full.
// R27: Ramp timer reloads and steps per expiry.
// R28: Sweep accumulator clamps at its limits.
package dds_pkg;

  localparam int ACC_W = 32;
  localparam int POW_W = 14;
  localparam int LUT_IN_W = 19;
  localparam int AMP_W = 14;
  localparam int RATE_W = 8;

  // Byte offsets on the register bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ASF = 8'h04;
  localparam logic [7:0] OFS_OSK_RATE = 8'h08;
  localparam logic [7:0] OFS_SWP_START = 8'h0C;
  localparam logic [7:0] OFS_SWP_TERM = 8'h10;
  localparam logic [7:0] OFS_DELTA_RISE = 8'h14;
  localparam logic [7:0] OFS_DELTA_FALL = 8'h18;
  localparam logic [7:0] OFS_SWP_RATE = 8'h1C;
  localparam logic [7:0] OFS_UPDATE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_ACT_CTRL = 8'h28;
  localparam logic [3:0] OFS_FTW_PAGE = 4'h4;
  localparam logic [3:0] OFS_POW_PAGE = 4'h5;

  // Bit positions in first_control_register.
  localparam int CTL_RAM_EN = 31;
  localparam int CTL_RAM_DEST = 30;
  localparam int CTL_OSK_EN = 25;
  localparam int CTL_OSK_AUTO = 24;
  localparam int CTL_SWEEP_EN = 21;
  localparam int CTL_AUTOCLR_FREQ = 14;
  localparam int CTL_AUTOCLR_PHASE = 13;
  localparam int CTL_CLR_FREQ = 11;
  localparam int CTL_CLR_PHASE = 10;
  localparam int CTL_COMP_PD = 6;
  localparam int CTL_NO_DWELL = 2;

  // Fields of amplitude_scale_register and status.
  localparam int ASF_STEP_HI = 15;
  localparam int ASF_STEP_LO = 14;
  localparam int STS_AT_TOP = 16;
  localparam int STS_AT_BOTTOM = 17;

  // Reset values, keying step sizes and the quarter-turn phase offset.
  localparam logic [31:0] CTRL_ACT_RST = 32'h0000_0400;
  localparam logic [31:0] CTRL_BUF_RST = 32'h0000_0000;
  localparam logic [AMP_W-1:0] SCALE_FULL = 14'h3FFF;
  localparam logic [AMP_W-1:0] OSK_STEP [4] = '{14'h0001, 14'h0002, 14'h0004, 14'h0008};
  localparam logic [LUT_IN_W-1:0] QUARTER_TURN = 19'h20000;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] amplitude_scale_register;
    logic [RATE_W-1:0] osk_rate;
    logic [ACC_W-1:0] swp_start;
    logic [ACC_W-1:0] swp_term;
    logic [ACC_W-1:0] delta_rise;
    logic [ACC_W-1:0] delta_fall;
    logic [RATE_W-1:0] rate_rise;
    logic [RATE_W-1:0] rate_fall;
  } cfg_s;

endpackage : dds_pkg

// ---- rtl/osk_scaler.sv ----
// Shaped on-off keying scale factor generator.
`timescale 1ns/100ps
module osk_scaler
  import dds_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control from the active register set.
  input wire logic enable,
  input wire logic auto_mode,
  input wire logic [15:0] amplitude_scale_register,
  input wire logic [RATE_W-1:0] ramp_rate,
  // Keying pin.
  input wire logic amplitude_keying_pin,
  // Scale factor to the multiplier.
  output logic [AMP_W-1:0] scale_q
);

  logic [RATE_W-1:0] tmr_q;
  logic [AMP_W-1:0] cnt_q;
  logic [AMP_W-1:0] step;
  logic expire;

  assign step = OSK_STEP[amplitude_scale_register[ASF_STEP_HI:ASF_STEP_LO]]; // R23
  assign expire = (tmr_q == '0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmr_q <= '0;
    end else if (!(enable && auto_mode) || expire) begin
      tmr_q <= ramp_rate; // R27
    end else begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // Saturating so that a held pin parks the amplitude instead of wrapping.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (enable && auto_mode && expire) begin
      if (amplitude_keying_pin) begin // R21
        cnt_q <= (cnt_q > SCALE_FULL - step) ? SCALE_FULL : cnt_q + step; // R26
      end else begin
        cnt_q <= (cnt_q < step) ? '0 : cnt_q - step; // R26
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scale_q <= SCALE_FULL;
    end else if (!enable) begin
      scale_q <= SCALE_FULL; // R18
    end else if (auto_mode) begin
      scale_q <= cnt_q; // R19 R20
    end else begin
      scale_q <= amplitude_scale_register[AMP_W-1:0]; // R19
    end
  end

endmodule : osk_scaler

// ---- tb/dac_model.sv ----
// DAC model that keeps its peak output swing.
`timescale 1ns/100ps
module dac_model
  import dds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [AMP_W-1:0] dac_code_q,
  input wire logic peak_clr,
  output logic [AMP_W-1:0] peak
);
  logic [AMP_W-1:0] mag;
  // Mid-scale is zero amplitude.
  always_comb begin
    mag = dac_code_q[AMP_W-1] ? (dac_code_q - 14'h2000) : (14'h2000 - dac_code_q);
  end
  always @(posedge clk_sys) begin
    if (peak_clr) begin
      peak <= 14'h0000;
    end else if (mag > peak) begin
      peak <= mag;
    end
  end
endmodule : dac_model

// ---- tb/dds_core_checker.sv ----
// Assertions on the core's ports.
`timescale 1ns/100ps
module dds_core_checker
  import dds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic io_update,
  input wire logic profile_select_low,
  input wire logic profile_select_high,
  input wire logic [AMP_W-1:0] dac_code_q,
  input wire logic comp_power_down
);
  logic io_q, psl_q, psh_q, quiet_q;
  logic [3:0] age_q;
  logic req, upd_c;
  assign req = avs_read | avs_write;
  // Any profile pin change counts, even one the core ignores.
  assign upd_c = (io_update & ~io_q) | (profile_select_low ^ psl_q) | (profile_select_high ^ psh_q)
    | (avs_write & ~avs_waitrequest & (avs_address == OFS_UPDATE) & avs_writedata[0]);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_q <= 1'b0;
      psl_q <= 1'b0;
      psh_q <= 1'b0;
      quiet_q <= 1'b1;
      age_q <= 4'h0;
    end else begin
      io_q <= io_update;
      psl_q <= profile_select_low;
      psh_q <= profile_select_high;
      quiet_q <= quiet_q & ~upd_c;
      age_q <= (age_q == 4'hF) ? age_q : age_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest stayed high");
  wait_rearm_a: assert property (req && !avs_waitrequest |=> avs_waitrequest == req)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[7]
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  pd_update_a: assert property (!$stable(comp_power_down) |-> $past(upd_c))
    else $error("power-down changed without update");
  act_reset_a: assert property (quiet_q && avs_read && !avs_waitrequest
    && avs_address == OFS_ACT_CTRL |-> avs_readdata == CTRL_ACT_RST)
    else $error("active control not reset");
  dac_still_a: assert property (quiet_q && age_q == 4'hF |=> $stable(dac_code_q))
    else $error("output moved while cleared");
endmodule : dds_core_checker

// ---- tb/tb_top.sv ----
// Self-checking testbench for the synthesizer datapath core.
`timescale 1ns/100ps
module tb_top
  import dds_pkg::*;
;
  localparam int PROFILES = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic io_update = 1'b0;
  logic profile_select_low = 1'b0;
  logic profile_select_high = 1'b0;
  logic amplitude_keying_pin = 1'b0;
  logic [31:0] ram_word = 32'h0;
  logic ram_rand = 1'b1;
  logic peak_clr = 1'b0;
  logic [31:0] avs_readdata, rd, last;
  logic avs_waitrequest, comp_power_down;
  logic [AMP_W-1:0] dac_code_q, peak;
  logic [13:0] w;
  integer seed = 11;
  int err_total = 0;
  int cmp_count = 0;
  dds_phase_amplitude_core #(.PROFILES(PROFILES)) u_dds_phase_amplitude_core (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .io_update(io_update),
    .profile_select_low(profile_select_low), .profile_select_high(profile_select_high),
    .amplitude_keying_pin(amplitude_keying_pin), .ram_word(ram_word),
    .dac_code_q(dac_code_q), .comp_power_down(comp_power_down));
  dac_model u_dac_model (.clk_sys(clk_sys), .dac_code_q(dac_code_q), .peak_clr(peak_clr),
    .peak(peak));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (ram_rand) begin
      ram_word <= $random(seed);
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Holds the request up to the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) err_total++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic pulse_update();
    io_update <= 1'b1;
    @(posedge clk_sys);
    io_update <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : pulse_update
  task automatic apply(input logic [31:0] ctl);
    bus(1'b1, OFS_CTRL, ctl);
    bus(1'b1, OFS_UPDATE, 32'h1);
    repeat (4) @(posedge clk_sys);
  endtask : apply
  // The two status reads sample three edges apart.
  task automatic span(input string what, input logic [13:0] exp);
    bus(1'b0, OFS_STATUS, 32'h0);
    last = rd;
    bus(1'b0, OFS_STATUS, 32'h0);
    check(what, {18'h0, exp}, {18'h0, rd[31:18] - last[31:18]});
  endtask : span
  task automatic measure();
    repeat (8) @(posedge clk_sys);
    peak_clr <= 1'b1;
    @(posedge clk_sys);
    peak_clr <= 1'b0;
    repeat (300) @(posedge clk_sys);
  endtask : measure
  function automatic logic [13:0] three_steps(input logic [13:0] v);
    return v + v + v;
  endfunction : three_steps
  function automatic logic scale_ok(input logic [13:0] v, input int s);
    logic [13:0] st;
    st = 14'h1 << s;
    return (v % st == 14'h0) && (v >= 8 * st) && (v <= 12 * st);
  endfunction : scale_ok
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #(40 * 30000);
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("pd_reset", 32'h0, {31'h0, comp_power_down});
    bus(1'b0, OFS_CTRL, 32'h0);
    check("ctrl_buf", CTRL_BUF_RST, rd);
    bus(1'b0, OFS_ACT_CTRL, 32'h0);
    check("ctrl_act", CTRL_ACT_RST, rd);
    bus(1'b1, 8'h84, 32'hFFFF_FFFF);
    bus(1'b0, 8'h84, 32'h0);
    check("unmapped", 32'h0, rd);
    bus(1'b1, 8'h40, 32'h0004_0000);
    span("held", 14'h0);
    bus(1'b1, OFS_CTRL, 32'h0000_0040);
    check("pd_early", 32'h0, {31'h0, comp_power_down});
    bus(1'b1, OFS_UPDATE, 32'h1);
    repeat (4) @(posedge clk_sys);
    check("pd_set", 32'h1, {31'h0, comp_power_down});
    span("one_step", 14'h3);
    for (int p = 0; p < PROFILES; p++) begin
      w = 14'($random(seed));
      bus(1'b1, 8'h40 + 8'(4 * p), {w, 18'h0});
      profile_select_low <= p[0];
      profile_select_high <= p[1];
      pulse_update();
      span("profile", three_steps(w));
    end
    bus(1'b1, 8'h4C, 32'h0);
    pulse_update();
    span("freeze", 14'h0);
    bus(1'b1, 8'h4C, 32'h0010_0000);
    apply(32'h0000_4400);
    span("clear", 14'h0);
    check("acc_zero", 32'h0, {18'h0, rd[31:18]});
    apply(32'h0000_2000);
    repeat (100) @(posedge clk_sys);
    pulse_update();
    bus(1'b0, OFS_STATUS, 32'h0);
    check("auto_clear", 32'h1, {31'h0, rd[31:18] < 14'h0028});
    ram_rand <= 1'b0;
    @(posedge clk_sys);
    w = 14'($random(seed));
    ram_word <= {w, 18'h0};
    apply(32'h8000_0000);
    span("ram", three_steps(w));
    w = ~w;
    bus(1'b1, OFS_SWP_START, {w, 18'h0});
    apply(32'h0020_0000);
    span("sweep", three_steps(w));
    ram_rand <= 1'b1;
    bus(1'b1, 8'h4C, 32'h0400_0000);
    bus(1'b1, OFS_ASF, 32'h0);
    apply(32'h0200_0000);
    measure();
    check("scale_zero", 32'h0, {18'h0, peak});
    bus(1'b1, OFS_ASF, 32'h0000_3FFF);
    pulse_update();
    measure();
    check("scale_full", 32'h1, {31'h0, peak > 14'h1800});
    bus(1'b1, OFS_OSK_RATE, 32'h0);
    bus(1'b1, OFS_ASF, 32'h0000_C000);
    apply(32'h0300_0000);
    amplitude_keying_pin <= 1'b1;
    repeat (2200) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("scale_top", 32'h3FFF, {18'h0, rd[13:0]});
    amplitude_keying_pin <= 1'b0;
    repeat (2200) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("scale_bottom", 32'h0, {18'h0, rd[13:0]});
    bus(1'b1, OFS_OSK_RATE, 32'h3);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, OFS_ASF, {16'h0, 2'(s), 14'h0});
      pulse_update();
      amplitude_keying_pin <= 1'b1;
      repeat (40) @(posedge clk_sys);
      bus(1'b0, OFS_STATUS, 32'h0);
      amplitude_keying_pin <= 1'b0;
      check("scale_step", 32'h1, {31'h0, scale_ok(rd[13:0], s)});
      repeat (100) @(posedge clk_sys);
    end
    apply(32'h0);
    amplitude_keying_pin <= 1'b0;
    final_report();
  end
endmodule : tb_top
bind dds_phase_amplitude_core dds_core_checker u_dds_core_checker (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .io_update(io_update),
  .profile_select_low(profile_select_low), .profile_select_high(profile_select_high),
  .dac_code_q(dac_code_q), .comp_power_down(comp_power_down));
